/* logic/uehc_pkg.sv */
package uehc_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [15:0] UEHC_ADDR_EP_BASE   = 16'h7f80;
	localparam logic [15:0] UEHC_ADDR_SETUP_MSK = 16'h7fac;
	localparam int          UEHC_NUM_EP         = 6;

	// ****************************************
	// Field positions and reset values
	// ****************************************
	localparam int UEHC_BIT_IN_ISO    = 7;
	localparam int UEHC_BIT_OUT_ISO   = 6;
	localparam int UEHC_BIT_IN_HI     = 5;
	localparam int UEHC_BIT_OUT_HI    = 4;
	localparam int UEHC_BIT_IN_LO     = 3;
	localparam int UEHC_BIT_OUT_LO    = 2;
	localparam int UEHC_BIT_IN_SEQ    = 1;
	localparam int UEHC_BIT_OUT_SEQ   = 0;
	localparam logic [7:0] UEHC_EP_RESET   = 8'h00;
	localparam logic [7:0] UEHC_MSK_RESET  = 8'h00;
	localparam logic [7:0] UEHC_MSK_WRMASK = 8'h3f;

	// ****************************************
	// Handshake control codes
	// ****************************************
	localparam logic [1:0] UEHC_HS_DISABLED = 2'h0;
	localparam logic [1:0] UEHC_HS_STALL    = 2'h1;
	localparam logic [1:0] UEHC_HS_NORMAL   = 2'h2;
	localparam logic [1:0] UEHC_HS_NAK      = 2'h3;

	typedef enum logic [1:0]
	{
		UEHC_TOK_OUT,
		UEHC_TOK_IN,
		UEHC_TOK_SETUP
	} uehc_tok_t;

	typedef enum logic [2:0]
	{
		UEHC_RSP_NONE,
		UEHC_RSP_ACK,
		UEHC_RSP_NAK,
		UEHC_RSP_STALL,
		UEHC_RSP_DATA
	} uehc_rsp_t;

	// Token from the decoder, one-cycle strobe
	typedef struct packed
	{
		logic       valid;
		uehc_tok_t  kind;
		logic [3:0] ep;
	} uehc_token_t;

	// Transaction outcome from the engine, one-cycle strobe
	typedef struct packed
	{
		logic valid;
		logic host_ack;
		logic data_rx;
		logic data_pid1;
	} uehc_done_t;

	// Decision back to the engine and buffer mover
	typedef struct packed
	{
		logic      valid;
		uehc_rsp_t rsp;
		logic      data_pid1;
		logic      iso;
	} uehc_decision_t;

endpackage

/* logic/uehc_ep_slot.sv */
`timescale 1ns/1ps
module uehc_ep_slot
	import uehc_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_sys_in,
	input  wire logic       resetn_in,
	// Software side
	input  wire logic       wr_in,
	input  wire logic [7:0] wdata_in,
	// Engine side
	input  wire logic       busy_in,
	input  wire logic       end_in,
	input  wire logic       in_good_in,
	input  wire logic       rx_seq_in,
	input  wire logic       rx_seq_val_in,
	// State
	output logic      [7:0] active_out
);

	logic [7:0] active_q;
	logic [7:0] active_d;
	logic [7:0] pend_q;
	logic [7:0] pend_d;
	logic       pend_vld_q;
	logic       pend_vld_d;

	// ****************************************
	// Held write and live settings
	// ****************************************
	always_comb
	begin
		active_d   = active_q;
		pend_d     = pend_q;
		pend_vld_d = pend_vld_q;
		if (wr_in && (busy_in && !end_in))
		begin
			pend_d     = wdata_in;
			pend_vld_d = 1'b1;
		end
		else if (wr_in)
		begin
			active_d   = {wdata_in[7:2], active_q[UEHC_BIT_IN_SEQ], active_q[UEHC_BIT_OUT_SEQ]};
			active_d[UEHC_BIT_IN_SEQ] = wdata_in[UEHC_BIT_IN_SEQ];
			pend_vld_d = 1'b0;
		end
		if (end_in)
		begin
			if (in_good_in)
				active_d[UEHC_BIT_IN_SEQ] = ~active_q[UEHC_BIT_IN_SEQ];
			if (rx_seq_val_in)
				active_d[UEHC_BIT_OUT_SEQ] = rx_seq_in;
			if (pend_vld_q && !wr_in)
			begin
				active_d[7:2] = pend_q[7:2];
				active_d[UEHC_BIT_IN_SEQ] = pend_q[UEHC_BIT_IN_SEQ];
				pend_vld_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			active_q   <= UEHC_EP_RESET;
			pend_q     <= UEHC_EP_RESET;
			pend_vld_q <= 1'b0;
		end
		else
		begin
			active_q   <= active_d;
			pend_q     <= pend_d;
			pend_vld_q <= pend_vld_d;
		end
	end

	assign active_out = active_q;

endmodule

/* logic/uehc_top.sv */
`timescale 1ns/1ps
// Overview of operation
// - IN code 00 silent, 01 STALL, 11 always NAK.
// - OUT code 00 silent, 01 STALL.
// - OUT code 10 ACK/NAK by buffer room, 11 always NAK.
// - IN sequence bit flips after each successful transmission, unless a held write lands then and sets it.
// - Bit 0 read-only, shows last received DATA0/DATA1.
// - Token endpoint number selects the governing control register.
// - Writes accepted anytime; a write to the endpoint in transaction is applied after that transaction ends, others at once.
// - Several writes during one transaction: only the last applies.
// - Setup-ignore bit set: SETUP token ignored, no response.
// - Setup-ignore bit clear: SETUP answered as control endpoint.
// - Non-iso IN needs host ACK to succeed; iso always succeeds.
module uehc_top
	import uehc_pkg::*;
#(
	parameter int NUM_EP = UEHC_NUM_EP
)
(
	// Clock and reset
	input  wire logic                  clk_sys_in,
	input  wire logic                  resetn_in,
	// APB slave
	input  wire logic                  psel_in,
	input  wire logic                  penable_in,
	input  wire logic                  pwrite_in,
	input  wire logic           [15:0] paddr_in,
	input  wire logic           [31:0] pwdata_in,
	input  wire logic            [3:0] pstrb_in,
	output logic                [31:0] prdata_out,
	output logic                       pready_out,
	output logic                       pslverr_out,
	// Engine side
	input  wire uehc_token_t           token_in,
	input  wire uehc_done_t            done_in,
	input  wire logic     [NUM_EP-1:0] tx_queue_full_in,
	input  wire logic     [NUM_EP-1:0] rx_room_in,
	output uehc_decision_t             decision_out,
	output logic                       in_release_out
);

	// ****************************************
	// Bus decode
	// ****************************************
	logic        acc;
	logic        wr_acc;
	logic        hit_ep;
	logic        hit_msk;
	logic [15:0] ep_off;
	logic  [2:0] ep_idx;
	logic [31:0] rdata;

	logic [7:0]       mask_q;
	logic [7:0]       mask_d;
	logic [31:0]      prdata_q;
	logic [31:0]      prdata_d;
	logic             slverr_q;
	logic             slverr_d;
	logic             ready_q;
	logic             ready_d;
	logic [7:0]       ep_reg [NUM_EP];
	logic [NUM_EP-1:0] ep_wr;

	assign acc    = psel_in && penable_in && !ready_q;
	assign wr_acc = acc && pwrite_in && pstrb_in[0];
	assign ep_off = paddr_in - UEHC_ADDR_EP_BASE;
	assign hit_ep  = (paddr_in >= UEHC_ADDR_EP_BASE) && (ep_off[15:2] < 14'(NUM_EP)) && (ep_off[1:0] == 2'h0);
	assign hit_msk = (paddr_in == UEHC_ADDR_SETUP_MSK);
	assign ep_idx  = ep_off[4:2];

	always_comb
	begin
		rdata = 32'h0000_0000;
		if (hit_ep)
			rdata = {24'h00_0000, ep_reg[ep_idx]};
		else if (hit_msk)
			rdata = {24'h00_0000, mask_q};
	end

	always_comb
	begin
		mask_d   = mask_q;
		prdata_d = prdata_q;
		slverr_d = 1'b0;
		ready_d  = 1'b0;
		if (acc)
		begin
			ready_d  = 1'b1;
			slverr_d = !(hit_ep || hit_msk);
			prdata_d = pwrite_in ? 32'h0000_0000 : rdata;
			if (wr_acc && hit_msk)
				mask_d = pwdata_in[7:0] & UEHC_MSK_WRMASK;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			mask_q   <= UEHC_MSK_RESET;
			prdata_q <= 32'h0000_0000;
			slverr_q <= 1'b0;
			ready_q  <= 1'b0;
		end
		else
		begin
			mask_q   <= mask_d;
			prdata_q <= prdata_d;
			slverr_q <= slverr_d;
			ready_q  <= ready_d;
		end
	end

	assign prdata_out  = prdata_q;
	assign pready_out  = ready_q;
	assign pslverr_out = slverr_q;

	// ****************************************
	// Transaction tracking
	// ****************************************
	logic       busy_q;
	logic       busy_d;
	logic [3:0] cur_ep_q;
	logic [3:0] cur_ep_d;
	logic       cur_in_q;
	logic       cur_in_d;
	logic [7:0] cur_reg;
	logic [7:0] tok_reg;
	logic       tok_known;
	logic       tok_ignore;

	always_comb
	begin
		busy_d   = busy_q;
		cur_ep_d = cur_ep_q;
		cur_in_d = cur_in_q;
		if (done_in.valid)
			busy_d = 1'b0;
		// Absent endpoints and masked SETUPs open no transaction
		if (token_in.valid && tok_known && !(token_in.kind == UEHC_TOK_SETUP && tok_ignore))
		begin
			busy_d   = 1'b1;
			cur_ep_d = token_in.ep;
			cur_in_d = (token_in.kind == UEHC_TOK_IN);
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			busy_q   <= 1'b0;
			cur_ep_q <= 4'h0;
			cur_in_q <= 1'b0;
		end
		else
		begin
			busy_q   <= busy_d;
			cur_ep_q <= cur_ep_d;
			cur_in_q <= cur_in_d;
		end
	end

	// ****************************************
	// Per-endpoint control registers
	// ****************************************
	logic cur_in_iso;
	logic cur_in_good;

	assign cur_in_good    = cur_in_q && (done_in.host_ack || cur_in_iso);
	assign in_release_out = done_in.valid && busy_q && cur_in_good;

	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++)
		begin : g_ep
			logic mine;
			assign mine     = busy_q && (cur_ep_q == 4'(g));
			assign ep_wr[g] = wr_acc && hit_ep && (ep_idx == 3'(g));
			uehc_ep_slot u_slot
			(
				.clk_sys_in    (clk_sys_in),
				.resetn_in     (resetn_in),
				.wr_in         (ep_wr[g]),
				.wdata_in      (pwdata_in[7:0]),
				.busy_in       (mine),
				.end_in        (mine && done_in.valid),
				.in_good_in    (cur_in_good),
				.rx_seq_in     (done_in.data_pid1),
				.rx_seq_val_in (!cur_in_q && done_in.data_rx),
				.active_out    (ep_reg[g])
			);
		end
	endgenerate

	// Endpoint numbers beyond the implemented set read as a disabled endpoint
	assign tok_known  = (token_in.ep < 4'(NUM_EP));
	assign tok_reg    = tok_known ? ep_reg[token_in.ep[2:0]] : UEHC_EP_RESET;
	assign cur_reg    = (cur_ep_q < 4'(NUM_EP)) ? ep_reg[cur_ep_q[2:0]] : UEHC_EP_RESET;
	assign cur_in_iso = cur_reg[UEHC_BIT_IN_ISO];
	assign tok_ignore = !tok_known || mask_q[token_in.ep[2:0]];

	// ****************************************
	// Handshake decision
	// ****************************************
	uehc_decision_t dec_q;
	uehc_decision_t dec_d;
	logic [1:0]     in_ctl;
	logic [1:0]     out_ctl;

	assign in_ctl  = {tok_reg[UEHC_BIT_IN_HI], tok_reg[UEHC_BIT_IN_LO]};
	assign out_ctl = {tok_reg[UEHC_BIT_OUT_HI], tok_reg[UEHC_BIT_OUT_LO]};

	always_comb
	begin
		dec_d           = '0;
		dec_d.rsp       = UEHC_RSP_NONE;
		dec_d.data_pid1 = tok_reg[UEHC_BIT_IN_SEQ];
		dec_d.iso       = tok_reg[UEHC_BIT_IN_ISO];
		if (token_in.valid)
		begin
			dec_d.valid = 1'b1;
			case (token_in.kind)
				UEHC_TOK_IN:
				begin
					case (in_ctl)
						UEHC_HS_STALL:  dec_d.rsp = UEHC_RSP_STALL;
						UEHC_HS_NORMAL: dec_d.rsp = tx_queue_full_in[token_in.ep[2:0]] ? UEHC_RSP_DATA : UEHC_RSP_NAK;
						UEHC_HS_NAK:    dec_d.rsp = UEHC_RSP_NAK;
						default:        dec_d.rsp = UEHC_RSP_NONE;
					endcase
				end
				UEHC_TOK_OUT:
				begin
					case (out_ctl)
						UEHC_HS_STALL:  dec_d.rsp = UEHC_RSP_STALL;
						UEHC_HS_NORMAL: dec_d.rsp = rx_room_in[token_in.ep[2:0]] ? UEHC_RSP_ACK : UEHC_RSP_NAK;
						UEHC_HS_NAK:    dec_d.rsp = UEHC_RSP_NAK;
						default:        dec_d.rsp = UEHC_RSP_NONE;
					endcase
				end
				UEHC_TOK_SETUP:
				begin
					if (tok_ignore)
						dec_d.valid = 1'b0;
					else
						dec_d.rsp = UEHC_RSP_ACK;
				end
				default: dec_d.rsp = UEHC_RSP_NONE;
			endcase
			if (!tok_known)
				dec_d.valid = 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			dec_q <= '0;
		else
			dec_q <= dec_d;
	end

	assign decision_out = dec_q;

endmodule

/* dv/uehc_assertions.sv */
`timescale 1ns/1ps
module uehc_chk
	import uehc_pkg::*;
#(
	parameter int NUM_EP = UEHC_NUM_EP
)
(
	// Clock and reset
	input wire logic           clk_sys_in,
	input wire logic           resetn_in,
	// APB
	input wire logic           psel_in,
	input wire logic           penable_in,
	input wire logic    [15:0] paddr_in,
	input wire logic    [31:0] prdata_out,
	input wire logic           pready_out,
	input wire logic           pslverr_out,
	// Engine
	input wire uehc_token_t    token_in,
	input wire uehc_done_t     done_in,
	input wire uehc_decision_t decision_out,
	input wire logic           in_release_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (!resetn_in);
	a_apb_answer: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("access not answered");
	a_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("pready too long");
	a_err_ready: assert property (pslverr_out |-> pready_out)
		else $error("pslverr without pready");
	a_byte_wide: assert property (pready_out |-> prdata_out[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	a_unmapped_err: assert property (psel_in && penable_in && !pready_out && paddr_in == 16'h7f98 |=> pslverr_out)
		else $error("unmapped not refused");
	a_dec_next: assert property (token_in.valid && token_in.ep < NUM_EP && token_in.kind != UEHC_TOK_SETUP
		|=> decision_out.valid)
		else $error("token not answered");
	a_dec_cause: assert property (decision_out.valid |-> $past(token_in.valid))
		else $error("decision without token");
	a_dec_range: assert property (token_in.valid && token_in.ep >= NUM_EP |=> !decision_out.valid)
		else $error("decision for absent endpoint");
	a_release_cause: assert property (in_release_out |-> done_in.valid)
		else $error("release without outcome");
endmodule

/* dv/uehc_host_model.sv */
`timescale 1ns/1ps
module uehc_host_model
	import uehc_pkg::*;
(
	// Clock and block feedback
	input  wire logic clk_sys_in,
	input  wire logic release_in,
	// Toward the block
	output uehc_token_t token_out,
	output uehc_done_t  done_out
);
	initial
	begin
		token_out = '0;
		done_out = '0;
	end
	// Idle endpoint and outcome fields are inverted so a stale value never looks valid by chance
	task automatic tok(input uehc_tok_t k, input logic [3:0] e);
		@(posedge clk_sys_in);
		token_out <= {1'b1, k, e};
		@(posedge clk_sys_in);
		token_out <= {1'b0, k, ~e};
	endtask
	task automatic fin(input logic a, input logic r, input logic p, output logic rel);
		@(posedge clk_sys_in);
		done_out <= {1'b1, a, r, p};
		#1 rel = release_in;
		@(posedge clk_sys_in);
		done_out <= {1'b0, ~a, ~r, ~p};
	endtask
endmodule

/* dv/uehc_top_tb.sv */
`timescale 1ns/1ps
module uehc_top_tb
	import uehc_pkg::*;
;
	logic           clk_sys_in = 1'b0;
	logic           resetn_in  = 1'b0;
	logic           psel_in    = 1'b0;
	logic           penable_in = 1'b0;
	logic           pwrite_in  = 1'b0;
	logic    [15:0] paddr_in   = 16'h0000;
	logic    [31:0] pwdata_in  = 32'h0000_0000;
	logic     [5:0] txq_in     = 6'h3f;
	logic     [5:0] room_in    = 6'h00;
	logic    [31:0] prdata_out;
	logic           pready_out;
	logic           pslverr_out;
	logic           in_release_out;
	uehc_token_t    token_in;
	uehc_done_t     done_in;
	uehc_decision_t decision_out;
	int             err_total       = 0;
	int             samples_checked = 0;
	int             cyc             = 0;

	initial
	begin
		forever #4 clk_sys_in = ~clk_sys_in;
	end

	uehc_top uehc_top_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
		.pstrb_in(4'hf), .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.token_in(token_in), .done_in(done_in), .tx_queue_full_in(txq_in), .rx_room_in(room_in),
		.decision_out(decision_out), .in_release_out(in_release_out));
	uehc_host_model uehc_host_model_i (.clk_sys_in(clk_sys_in), .release_in(in_release_out),
		.token_out(token_in), .done_out(done_in));

	// ****************************************
	// Checks and bus cycles
	// ****************************************
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	function automatic logic [15:0] ea(input int n);
		return UEHC_ADDR_EP_BASE + 16'(4 * n);
	endfunction
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic e);
		@(posedge clk_sys_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		do @(posedge clk_sys_in); while (pready_out !== 1'b1);
		q = prdata_out;
		e = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, {24'h00_0000, d}, q, e);
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] exp, input logic ee);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		chk(q, exp);
		chk({31'h0000_0000, e}, {31'h0000_0000, ee});
	endtask
	// Decision is sampled one cycle after the token, while it stands
	task automatic tokchk(input uehc_tok_t k, input logic [3:0] e, input logic v, input uehc_rsp_t r);
		uehc_host_model_i.tok(k, e);
		#1;
		chk({31'h0000_0000, decision_out.valid}, {31'h0000_0000, v});
		if (v)
			chk(32'(decision_out.rsp), 32'(r));
	endtask
	task automatic fin(input logic a, input logic r, input logic p, input logic er);
		logic rel;
		uehc_host_model_i.fin(a, r, p, rel);
		chk({31'h0000_0000, rel}, {31'h0000_0000, er});
	endtask
	task automatic one(input uehc_tok_t k, input int ep, input logic [7:0] d, input uehc_rsp_t r);
		wr(ea(ep), d);
		tokchk(k, 4'(ep), 1'b1, r);
		fin(1'b0, 1'b0, 1'b0, 1'b0);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic s_regs();
		for (int n = 0; n < 6; n++)
		begin
			rd(ea(n), 32'h0000_0000, 1'b0);
			wr(ea(n), 8'hff);
			rd(ea(n), 32'h0000_00fe, 1'b0);
			wr(ea(n), 8'h02);
			wr(ea(n), 8'h00);
		end
		wr(UEHC_ADDR_SETUP_MSK, 8'h3f);
		rd(UEHC_ADDR_SETUP_MSK, 32'h0000_003f, 1'b0);
		wr(UEHC_ADDR_SETUP_MSK, 8'h00);
		rd(16'h7f98, 32'h0000_0000, 1'b1);
	endtask
	task automatic s_codes(input uehc_tok_t k, input int ep, input int hi, input int lo, input logic [11:0] r);
		for (int c = 0; c < 4; c++)
			one(k, ep, 8'(((c >> 1) << hi) | ((c & 1) << lo)), uehc_rsp_t'(r[3 * c +: 3]));
	endtask
	task automatic s_toggle();
		wr(ea(2), 8'h20);
		tokchk(UEHC_TOK_IN, 4'h2, 1'b1, UEHC_RSP_DATA);
		chk({31'h0000_0000, decision_out.data_pid1}, 32'h0000_0000);
		fin(1'b1, 1'b0, 1'b0, 1'b1);
		rd(ea(2), 32'h0000_0022, 1'b0);
		tokchk(UEHC_TOK_IN, 4'h2, 1'b1, UEHC_RSP_DATA);
		chk({31'h0000_0000, decision_out.data_pid1}, 32'h0000_0001);
		fin(1'b0, 1'b0, 1'b0, 1'b0);
		rd(ea(2), 32'h0000_0022, 1'b0);
		wr(ea(2), 8'ha2);
		tokchk(UEHC_TOK_IN, 4'h2, 1'b1, UEHC_RSP_DATA);
		chk({31'h0000_0000, decision_out.iso}, 32'h0000_0001);
		fin(1'b0, 1'b0, 1'b0, 1'b1);
		rd(ea(2), 32'h0000_00a0, 1'b0);
	endtask
	task automatic s_defer();
		wr(ea(3), 8'h20);
		tokchk(UEHC_TOK_IN, 4'h3, 1'b1, UEHC_RSP_DATA);
		wr(ea(3), 8'h08);
		wr(ea(3), 8'h28);
		rd(ea(3), 32'h0000_0020, 1'b0);
		fin(1'b1, 1'b0, 1'b0, 1'b1);
		rd(ea(3), 32'h0000_0028, 1'b0);
		one(UEHC_TOK_IN, 3, 8'h28, UEHC_RSP_NAK);
	endtask
	task automatic s_setup();
		wr(UEHC_ADDR_SETUP_MSK, 8'h3e);
		tokchk(UEHC_TOK_SETUP, 4'h1, 1'b0, UEHC_RSP_NONE);
		tokchk(UEHC_TOK_SETUP, 4'h0, 1'b1, UEHC_RSP_ACK);
		fin(1'b0, 1'b1, 1'b1, 1'b0);
		rd(ea(0), 32'h0000_0001, 1'b0);
		tokchk(UEHC_TOK_IN, 4'h6, 1'b0, UEHC_RSP_NONE);
	endtask

	initial
	begin
		repeat (20) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		s_regs();
		s_codes(UEHC_TOK_IN, 1, 5, 3, {UEHC_RSP_NAK, UEHC_RSP_DATA, UEHC_RSP_STALL, UEHC_RSP_NONE});
		@(posedge clk_sys_in);
		txq_in <= 6'h3d;
		one(UEHC_TOK_IN, 1, 8'h20, UEHC_RSP_NAK);
		s_codes(UEHC_TOK_OUT, 4, 4, 2, {UEHC_RSP_NAK, UEHC_RSP_NAK, UEHC_RSP_STALL, UEHC_RSP_NONE});
		@(posedge clk_sys_in);
		room_in <= 6'h10;
		one(UEHC_TOK_OUT, 4, 8'h10, UEHC_RSP_ACK);
		txq_in <= 6'h3f;
		s_toggle();
		s_defer();
		s_setup();
		end_sim();
	end

	// A hang ends the run as a mismatch
	always @(posedge clk_sys_in)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			err_total++;
			end_sim();
		end
	end
endmodule

bind uehc_top uehc_chk #(.NUM_EP(NUM_EP)) uehc_chk_i (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
	.psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
	.pready_out(pready_out), .pslverr_out(pslverr_out), .token_in(token_in), .done_in(done_in),
	.decision_out(decision_out), .in_release_out(in_release_out));
